// >>> hw/pmic_pm_indirect_cfg.sv
// power management capability and indirect config access, apb slave
`timescale 1ns/1ps
module pmic_pm_indirect_cfg #(
  parameter int IDX_W = pmic_pkg::IDX_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power state towards the endpoint
  output logic [1:0] power_state
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] power_state_q;
  logic dsi_q;
  pmic_pkg::pmic_ptr_t ptr_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] mem_rdata;

  function automatic logic is_local(input logic [9:0] idx);
    is_local = (idx == pmic_pkg::IDX_PM_HDR) || (idx == pmic_pkg::IDX_PM_CSR) ||
               (idx == pmic_pkg::IDX_PTR) || (idx == pmic_pkg::IDX_WIN);
  endfunction : is_local

  function automatic logic ps_legal(input logic [1:0] code);
    ps_legal = (code == pmic_pkg::PS_FULL_ON) || (code == pmic_pkg::PS_HOT_OFF);
  endfunction : ps_legal

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic acc_first = psel & penable & ~pready_q;
  wire logic done = psel & penable & pready_q;
  wire logic addr_ok = (paddr[31:pmic_pkg::ADDR_W] == 20'h00000);
  wire logic [9:0] dir_idx = paddr[pmic_pkg::ADDR_W-1:2];
  wire logic via_win = (dir_idx == pmic_pkg::IDX_WIN);
  wire logic [9:0] tgt_idx = via_win ? ptr_q : dir_idx;
  wire logic tgt_blocked = via_win & (ptr_q == pmic_pkg::IDX_WIN);
  wire logic wr_go = done & pwrite & addr_ok & ~tgt_blocked;
  wire logic wr_hdr = wr_go & (tgt_idx == pmic_pkg::IDX_PM_HDR);
  wire logic wr_csr = wr_go & (tgt_idx == pmic_pkg::IDX_PM_CSR);
  wire logic wr_ptr = wr_go & (tgt_idx == pmic_pkg::IDX_PTR);
  wire logic wr_mem = wr_go & ~is_local(tgt_idx);
  wire logic [1:0] ps_wdata = pwdata[pmic_pkg::PS_LSB +: 2];

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  wire logic [31:0] hdr_word = {
    pmic_pkg::WAKE_EVENT_SUPPORT,
    pmic_pkg::DEEP_SLEEP_SUPPORT,
    pmic_pkg::LIGHT_SLEEP_SUPPORT,
    pmic_pkg::AUXILIARY_CURRENT,
    dsi_q,
    1'h0,
    pmic_pkg::WAKE_CLOCK_REQUIRED,
    pmic_pkg::CAPABILITY_VERSION,
    pmic_pkg::NEXT_CAPABILITY_POINTER,
    pmic_pkg::CAPABILITY_IDENTIFIER
  };
  wire logic [31:0] csr_word = {
    pmic_pkg::POWER_DATA,
    pmic_pkg::BUS_POWER_CLOCK_CONTROL_ENABLE,
    pmic_pkg::BUS_POWER_STATE_SUPPORT,
    6'h00,
    pmic_pkg::WAKE_EVENT_STATUS,
    pmic_pkg::POWER_DATA_SCALE,
    pmic_pkg::POWER_DATA_SELECT,
    pmic_pkg::WAKE_EVENT_ENABLE,
    6'h00,
    power_state_q
  };
  wire logic [31:0] ptr_word = {20'h00000, ptr_q, 2'h0};
  wire logic [31:0] rd_word =
    (tgt_blocked || !addr_ok) ? 32'h0000_0000 :
    (tgt_idx == pmic_pkg::IDX_PM_HDR) ? hdr_word :
    (tgt_idx == pmic_pkg::IDX_PM_CSR) ? csr_word :
    (tgt_idx == pmic_pkg::IDX_PTR) ? ptr_word :
    mem_rdata;

  // ----------------------------------------------------------------
  // configuration store
  // ----------------------------------------------------------------
  // read is issued every cycle from the setup address, so the data is
  // ready at the first access edge; this costs one wait state per access
  pmic_cfg_mem #(
    .IDX_W(IDX_W)
  ) u_mem (
    .core_clk(core_clk),
    .reset(reset),
    .we(wr_mem),
    .wstrb(pstrb),
    .widx(tgt_idx[IDX_W-1:0]),
    .wdata(pwdata),
    .ridx(tgt_idx[IDX_W-1:0]),
    .rdata_q(mem_rdata)
  );

  // ----------------------------------------------------------------
  // bus response
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (acc_first) begin
      pready_q <= 1'b1;
      pslverr_q <= ~addr_ok;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      power_state_q <= pmic_pkg::PS_RST;
      dsi_q <= pmic_pkg::DSI_RST;
    end else begin
      if (wr_csr && pstrb[pmic_pkg::PS_LANE] && ps_legal(ps_wdata)) begin
        power_state_q <= ps_wdata;
      end
      if (wr_hdr && pstrb[pmic_pkg::DSI_LANE]) begin
        dsi_q <= pwdata[pmic_pkg::DSI_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr_q <= pmic_pkg::PTR_RST;
    end else begin
      if (wr_ptr && pstrb[pmic_pkg::REG_LANE]) begin
        ptr_q.register_number <= pwdata[pmic_pkg::REG_MSB:pmic_pkg::REG_LSB];
      end
      if (wr_ptr && pstrb[pmic_pkg::EXTENDED_REGISTER_NUMBER_LANE]) begin
        ptr_q.extended_register_number <= pwdata[pmic_pkg::EXTENDED_REGISTER_NUMBER_MSB:pmic_pkg::EXTENDED_REGISTER_NUMBER_LSB];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign power_state = power_state_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire logic rd_done = done & ~pwrite & addr_ok;
  wire logic rd_hdr = rd_done & (dir_idx == pmic_pkg::IDX_PM_HDR);
  wire logic rd_csr = rd_done & (dir_idx == pmic_pkg::IDX_PM_CSR);
  wire logic rd_ptr = rd_done & (dir_idx == pmic_pkg::IDX_PTR);

  property p_cap_id;
    @(posedge core_clk) disable iff (reset)
    rd_hdr |-> prdata[7:0] == pmic_pkg::CAPABILITY_IDENTIFIER;
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("capability id wrong");

  property p_next_ptr;
    @(posedge core_clk) disable iff (reset)
    rd_hdr |-> prdata[15:8] == pmic_pkg::NEXT_CAPABILITY_POINTER;
  endproperty
  a_next_ptr: assert property (p_next_ptr) else $error("next pointer not zero");

  property p_version;
    @(posedge core_clk) disable iff (reset)
    rd_hdr |-> prdata[18:16] == pmic_pkg::CAPABILITY_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("capability version wrong");

  property p_hdr_zeros;
    @(posedge core_clk) disable iff (reset)
    rd_hdr |-> (prdata[31:22] == 10'h000) && (prdata[20:19] == 2'h0);
  endproperty
  a_hdr_zeros: assert property (p_hdr_zeros) else $error("header zero field set");

  property p_dsi_reset;
    @(posedge core_clk)
    reset |=> !dsi_q;
  endproperty
  a_dsi_reset: assert property (p_dsi_reset) else $error("init bit not cleared by reset");

  property p_ps_legal;
    @(posedge core_clk) disable iff (reset)
    ps_legal(power_state_q) and (rd_csr |-> prdata[1:0] == power_state_q);
  endproperty
  a_ps_legal: assert property (p_ps_legal) else $error("power state illegal");

  property p_ps_write;
    @(posedge core_clk) disable iff (reset)
    wr_csr && pstrb[pmic_pkg::PS_LANE] && ps_legal(ps_wdata) |=> power_state_q == $past(ps_wdata);
  endproperty
  a_ps_write: assert property (p_ps_write) else $error("power state write lost");

  property p_ps_reserved;
    @(posedge core_clk) disable iff (reset)
    wr_csr && !ps_legal(ps_wdata) |=> $stable(power_state_q);
  endproperty
  a_ps_reserved: assert property (p_ps_reserved) else $error("reserved code accepted");

  property p_csr_zeros;
    @(posedge core_clk) disable iff (reset)
    rd_csr |-> prdata[31:2] == 30'h0000_0000;
  endproperty
  a_csr_zeros: assert property (p_csr_zeros) else $error("status zero field set");

  property p_ptr_read;
    @(posedge core_clk) disable iff (reset)
    rd_ptr |-> prdata == {20'h00000, ptr_q, 2'h0};
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer readback wrong");

  property p_win_read;
    @(posedge core_clk) disable iff (reset)
    rd_done && via_win && (ptr_q == pmic_pkg::IDX_PM_HDR) |->
      prdata[7:0] == pmic_pkg::CAPABILITY_IDENTIFIER;
  endproperty
  a_win_read: assert property (p_win_read) else $error("window read wrong");

  property p_win_write;
    @(posedge core_clk) disable iff (reset)
    wr_ptr && via_win && (pstrb[1:0] == 2'h3) |=>
      ptr_q == $past(pwdata[11:2]);
  endproperty
  a_win_write: assert property (p_win_write) else $error("window write lost");

  property p_strobe;
    @(posedge core_clk) disable iff (reset)
    wr_ptr && !pstrb[0] |=> $stable(ptr_q.register_number);
  endproperty
  a_strobe: assert property (p_strobe) else $error("disabled byte written");

  property p_win_self;
    @(posedge core_clk) disable iff (reset)
    (rd_done && tgt_blocked |-> prdata == 32'h0000_0000) and
    (done && pwrite && tgt_blocked |=> $stable(ptr_q));
  endproperty
  a_win_self: assert property (p_win_self) else $error("self window not inert");

  property p_ptr_write;
    @(posedge core_clk) disable iff (reset)
    wr_ptr && pstrb[pmic_pkg::REG_LANE] |=>
      ptr_q.register_number == $past(pwdata[pmic_pkg::REG_MSB:pmic_pkg::REG_LSB]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("dword number write lost");

  property p_ext_write;
    @(posedge core_clk) disable iff (reset)
    wr_ptr && pstrb[pmic_pkg::EXTENDED_REGISTER_NUMBER_LANE] |=>
      ptr_q.extended_register_number == $past(pwdata[pmic_pkg::EXTENDED_REGISTER_NUMBER_MSB:pmic_pkg::EXTENDED_REGISTER_NUMBER_LSB]);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("extended number write lost");

  property p_ext_strobe;
    @(posedge core_clk) disable iff (reset)
    wr_ptr && !pstrb[pmic_pkg::EXTENDED_REGISTER_NUMBER_LANE] |=> $stable(ptr_q.extended_register_number);
  endproperty
  a_ext_strobe: assert property (p_ext_strobe) else $error("disabled ext byte written");

  property p_dsi_write;
    @(posedge core_clk) disable iff (reset)
    wr_hdr && pstrb[pmic_pkg::DSI_LANE] |=> dsi_q == $past(pwdata[pmic_pkg::DSI_BIT]);
  endproperty
  a_dsi_write: assert property (p_dsi_write) else $error("init bit write lost");

  property p_dsi_hold;
    @(posedge core_clk) disable iff (reset)
    wr_hdr && !pstrb[pmic_pkg::DSI_LANE] |=> $stable(dsi_q);
  endproperty
  a_dsi_hold: assert property (p_dsi_hold) else $error("init bit written without lane");

  // a refused write must leave every writable field alone
  property p_refused;
    @(posedge core_clk) disable iff (reset)
    done && pwrite && !addr_ok |=> $stable(power_state_q) && $stable(ptr_q) && $stable(dsi_q);
  endproperty
  a_refused: assert property (p_refused) else $error("refused write took effect");

  property p_err_flag;
    @(posedge core_clk) disable iff (reset)
    done |-> pslverr == !addr_ok;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag wrong");

  property p_err_pulse;
    @(posedge core_clk) disable iff (reset)
    pslverr |-> pready;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error flag without ready");

  property p_wr_rdata;
    @(posedge core_clk) disable iff (reset)
    done && pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_wr_rdata: assert property (p_wr_rdata) else $error("read data on a write");

  property p_win_mem;
    @(posedge core_clk) disable iff (reset)
    rd_done && via_win && !tgt_blocked && !is_local(ptr_q) |-> prdata == mem_rdata;
  endproperty
  a_win_mem: assert property (p_win_mem) else $error("window store read wrong");

  // reset state of every output and of the pointer
  property p_reset_out;
    @(posedge core_clk)
    reset |=> !pready && !pslverr && (prdata == 32'h0000_0000) &&
      (power_state == pmic_pkg::PS_RST) && (ptr_q == pmic_pkg::PTR_RST);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset state wrong");

  property p_answer;
    @(posedge core_clk) disable iff (reset)
    acc_first |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("pready timing wrong");

endmodule : pmic_pm_indirect_cfg

// >>> hw/pmic_pkg.sv
// constants and types shared by the power management and indirect config block
package pmic_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [11:0] OFF_PM_CAPABILITY_HEADER = 12'h0f0;
  localparam logic [11:0] OFF_PM_CONTROL_STATUS = 12'h0f4;
  localparam logic [11:0] OFF_INDIRECT_CONFIG_POINTER = 12'h0f8;
  localparam logic [11:0] OFF_INDIRECT_CONFIG_WINDOW = 12'h0fc;
  localparam logic [9:0] IDX_PM_HDR = OFF_PM_CAPABILITY_HEADER[11:2];
  localparam logic [9:0] IDX_PM_CSR = OFF_PM_CONTROL_STATUS[11:2];
  localparam logic [9:0] IDX_PTR = OFF_INDIRECT_CONFIG_POINTER[11:2];
  localparam logic [9:0] IDX_WIN = OFF_INDIRECT_CONFIG_WINDOW[11:2];

  // ----------------------------------------------------------------
  // capability header constants and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CAPABILITY_IDENTIFIER = 8'h01;
  localparam logic [7:0] NEXT_CAPABILITY_POINTER = 8'h00;
  localparam logic [2:0] CAPABILITY_VERSION = 3'h2;
  localparam logic [0:0] WAKE_CLOCK_REQUIRED = 1'h0;
  localparam logic [2:0] AUXILIARY_CURRENT = 3'h0;
  localparam logic [0:0] LIGHT_SLEEP_SUPPORT = 1'h0;
  localparam logic [0:0] DEEP_SLEEP_SUPPORT = 1'h0;
  localparam logic [4:0] WAKE_EVENT_SUPPORT = 5'h00;
  localparam int DSI_BIT = 21;
  localparam int DSI_LANE = 2;

  // ----------------------------------------------------------------
  // control and status constants
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_FULL_ON = 2'h0;
  localparam logic [1:0] PS_HOT_OFF = 2'h3;
  localparam logic [0:0] WAKE_EVENT_ENABLE = 1'h0;
  localparam logic [3:0] POWER_DATA_SELECT = 4'h0;
  localparam logic [1:0] POWER_DATA_SCALE = 2'h0;
  localparam logic [0:0] WAKE_EVENT_STATUS = 1'h0;
  localparam logic [0:0] BUS_POWER_STATE_SUPPORT = 1'h0;
  localparam logic [0:0] BUS_POWER_CLOCK_CONTROL_ENABLE = 1'h0;
  localparam logic [7:0] POWER_DATA = 8'h00;
  localparam int PS_LSB = 0;
  localparam int PS_LANE = 0;

  // ----------------------------------------------------------------
  // pointer field positions and reset values
  // ----------------------------------------------------------------
  localparam int REG_LSB = 2;
  localparam int REG_MSB = 7;
  localparam int EXTENDED_REGISTER_NUMBER_LSB = 8;
  localparam int EXTENDED_REGISTER_NUMBER_MSB = 11;
  localparam int REG_LANE = 0;
  localparam int EXTENDED_REGISTER_NUMBER_LANE = 1;
  localparam logic [0:0] DSI_RST = 1'h0;
  localparam logic [1:0] PS_RST = PS_FULL_ON;

  typedef struct packed {
    logic [3:0] extended_register_number;
    logic [5:0] register_number;
  } pmic_ptr_t;

  localparam pmic_ptr_t PTR_RST = 10'h000;

endpackage : pmic_pkg

// >>> hw/pmic_cfg_mem.sv
// byte-writable dword store for the configuration space behind the window
`timescale 1ns/1ps
module pmic_cfg_mem #(
  parameter int IDX_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // write side
  input wire logic we,
  input wire logic [3:0] wstrb,
  input wire logic [IDX_W-1:0] widx,
  input wire logic [31:0] wdata,
  // read side, data one cycle after index
  input wire logic [IDX_W-1:0] ridx,
  output logic [31:0] rdata_q
);

  // one array per byte lane, so that each array has a single writer
  logic [3:0][7:0] lane_rd;

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane_mem [0:(1<<IDX_W)-1];
    always_ff @(posedge core_clk) begin
      if (we && wstrb[b]) begin
        lane_mem[widx] <= wdata[8*b +: 8];
      end
    end
    assign lane_rd[b] = lane_mem[ridx];
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= lane_rd;
    end
  end

endmodule : pmic_cfg_mem

// >>> dv/pmic_testbench.sv
// self-checking bench for the power management and indirect config block
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] power_state;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [31:0] HDR = {20'h0, pmic_pkg::OFF_PM_CAPABILITY_HEADER};
  localparam logic [31:0] CSR = {20'h0, pmic_pkg::OFF_PM_CONTROL_STATUS};
  localparam logic [31:0] PTR = {20'h0, pmic_pkg::OFF_INDIRECT_CONFIG_POINTER};
  localparam logic [31:0] WIN = {20'h0, pmic_pkg::OFF_INDIRECT_CONFIG_WINDOW};
  // id one, next zero, version two, everything else zero
  localparam logic [31:0] HDR_RST = 32'h0002_0001;

  pmic_pm_indirect_cfg uut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_state(power_state)
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // a hang in a wait is cut short here
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1; // only this side's pointer and window pair is used
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // pready is sampled at the edge, before that edge's updates land
    // only the global cycle ceiling bounds this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk(what, exp, r);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_header;
    rd_chk("header reset", HDR, HDR_RST);
    wr(HDR, 32'hffff_ffff, 4'hf);
    // only the init bit may take the write
    rd_chk("header ones", HDR, HDR_RST | 32'h0020_0000);
    wr(HDR, 32'h0, 4'hb);
    rd_chk("header no lane2", HDR, HDR_RST | 32'h0020_0000);
    wr(HDR, 32'h0, 4'h4);
    rd_chk("header cleared", HDR, HDR_RST);
  endtask : t_header

  task automatic t_power;
    rd_chk("csr reset", CSR, 32'h0);
    wr(CSR, 32'hffff_ffff, 4'hf);
    rd_chk("csr ones", CSR, 32'h3);
    chk("power_state off", 32'h3, {30'h0, power_state});
    wr(CSR, 32'h1, 4'hf);
    rd_chk("csr code1", CSR, 32'h3);
    wr(CSR, 32'h2, 4'hf);
    rd_chk("csr code2", CSR, 32'h3);
    wr(CSR, 32'h0, 4'he);
    rd_chk("csr no lane0", CSR, 32'h3);
    wr(CSR, 32'h0, 4'h1);
    rd_chk("csr on", CSR, 32'h0);
    chk("power_state on", 32'h0, {30'h0, power_state});
  endtask : t_power

  task automatic t_pointer_self;
    rd_chk("pointer reset", PTR, 32'h0);
    wr(PTR, 32'hffff_ffff, 4'hf);
    rd_chk("pointer ones", PTR, 32'h0000_0ffc);
    // the window itself is dword 0x3f at offset 0x0fc, extended number zero
    wr(PTR, WIN, 4'hf);
    rd_chk("window self", WIN, 32'h0);
    wr(WIN, 32'h0000_0123, 4'hf);
    rd_chk("pointer kept", PTR, 32'h0000_00fc);
    wr(PTR, 32'h0000_0f00, 4'h2);
    rd_chk("pointer lane1", PTR, 32'h0000_0ffc);
  endtask : t_pointer_self

  task automatic t_window;
    wr(PTR, 32'h0000_0100, 4'hf);
    wr(WIN, 32'ha5a5_a5a5, 4'hf);
    rd_chk("direct after window", 32'h100, 32'ha5a5_a5a5);
    wr(WIN, 32'h1122_3344, 4'h5);
    rd_chk("window strobes", 32'h100, 32'ha522_a544);
    rd_chk("window read", WIN, 32'ha522_a544);
    wr(32'h0000_0a04, 32'h5566_7788, 4'hf);
    wr(PTR, 32'h0000_0a04, 4'hf);
    rd_chk("window extended", WIN, 32'h5566_7788);
    wr(PTR, HDR, 4'hf);
    rd_chk("window header", WIN, HDR_RST);
    wr(PTR, CSR, 4'hf);
    wr(WIN, 32'h3, 4'h1);
    rd_chk("csr via window off", CSR, 32'h3);
    chk("power_state via window", 32'h3, {30'h0, power_state});
    wr(WIN, 32'h0, 4'h1);
    rd_chk("csr via window", CSR, 32'h0);
    wr(PTR, PTR, 4'hf);
    wr(WIN, 32'h0000_0100, 4'h3);
    rd_chk("pointer via window", PTR, 32'h0000_0100);
  endtask : t_window

  task automatic t_out_of_range;
    logic [31:0] r;
    logic e;
    apb(1'b1, 32'h0000_1100, 32'hdead_beef, 4'hf, r, e);
    chk("write pslverr", 32'h1, {31'h0, e});
    apb(1'b0, 32'h0000_1100, 32'h0, 4'h0, r, e);
    chk("read pslverr", 32'h1, {31'h0, e});
    chk("read data refused", 32'h0, r);
    rd_chk("alias untouched", 32'h100, 32'ha522_a544);
  endtask : t_out_of_range

  task automatic t_reset;
    wr(HDR, 32'h0020_0000, 4'h4);
    wr(CSR, 32'h3, 4'h1);
    wr(PTR, 32'h0000_0abc, 4'hf);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk("header after reset", HDR, HDR_RST);
    rd_chk("pointer after reset", PTR, 32'h0);
    rd_chk("csr after reset", CSR, 32'h0);
    chk("power_state after reset", 32'h0, {30'h0, power_state});
  endtask : t_reset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    chk("power_state reset", 32'h0, {30'h0, power_state});
    t_header();
    t_power();
    t_pointer_self();
    t_window();
    t_out_of_range();
    t_reset();
    tally_and_finish();
  end
endmodule : testbench
